// ---- pkg/edcca_params.svh ----
// Register offsets, field positions, reset values and codes for the energy-detect and channel-assessment block
`ifndef EDCCA_PARAMS_SVH
`define EDCCA_PARAMS_SVH
`define EDCCA_OFS_REPEAT 12'h664
`define EDCCA_OFS_LEVEL 12'h668
`define EDCCA_OFS_CTRL 12'h66c
`define EDCCA_OFS_CMD 12'h670
`define EDCCA_OFS_STATUS 12'h674
`define EDCCA_CTRL_RESET 32'h052d0000
`define EDCCA_MODE_LSB 0
`define EDCCA_MODE_MSB 2
`define EDCCA_EDTH_LSB 8
`define EDCCA_EDTH_MSB 15
`define EDCCA_CTH_LSB 16
`define EDCCA_CTH_MSB 23
`define EDCCA_CNT_LSB 24
`define EDCCA_CNT_MSB 31
`define EDCCA_CMD_ED 0
`define EDCCA_CMD_CCA 1
`define EDCCA_ST_EDEND 0
`define EDCCA_ST_BUSY 1
`define EDCCA_ST_IDLE 2
`define EDCCA_ST_RUN 3
`define EDCCA_ADDR_W 12
`endif

// ---- pkg/edcca_pkg.sv ----
// Types for the energy-detect and channel-assessment block
package edcca_pkg;
  typedef enum logic [2:0] {
    EDCCA_ENERGY_ONLY = 3'h0,
    EDCCA_CARRIER_ONLY = 3'h1,
    EDCCA_CARRIER_AND_ENERGY = 3'h2,
    EDCCA_CARRIER_OR_ENERGY = 3'h3,
    EDCCA_ENERGY_FIRST_HIT_TEST = 3'h4
  } edcca_mode_t;
  typedef enum logic [1:0] {
    EDCCA_IDLE = 2'b00,
    EDCCA_SCAN = 2'b01,
    EDCCA_ASSESS = 2'b10
  } edcca_fsm_t;
  typedef struct packed {
    logic [31:0] repeat_count;
    logic [7:0] level;
    logic [31:0] ctrl;
    edcca_fsm_t fsm;
    logic [31:0] left;
    logic [7:0] hits;
    logic energy_seen;
    logic ed_end;
    logic cca_busy;
    logic cca_idle;
    logic ack;
    logic [31:0] dat;
  } edcca_state_t;
endpackage

// ---- design/edcca_core.sv ----
// Energy-detect scan and channel-assessment engine with a classic Wishbone slave
// Behaviour
// - A repeat count of 0 gives one energy scan and a count of N gives N plus 1 scans.
// - The highest energy seen over all scans of one operation is kept in the level result register.
// - First-hit test mode ends the assessment at the first sample over threshold, with no averaging.
// - Energy is compared with the energy threshold in every mode but carrier only.
// - The correlator threshold counts only in the three carrier modes.
// - A nonzero hit limit enables correlator detection and zero disables it.
`timescale 1ns/1ps
`include "edcca_params.svh"
module edcca_core (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SAMPLE_VALID,
  input wire logic [7:0] SAMPLE_ENERGY,
  input wire logic [7:0] SAMPLE_CORR,
  input wire logic ASSESS_WINDOW_END,
  output logic ED_END,
  output logic CCA_BUSY,
  output logic CCA_IDLE
);
  edcca_pkg::edcca_state_t cur, nxt;
  logic req, wr;
  logic [2:0] mode;
  logic [7:0] ed_th, c_th, c_lim;
  logic over_ed, over_c, carrier, busy_now;
  logic [31:0] wmask;
  assign req = WB_CYC_I && WB_STB_I && !cur.ack;
  assign wr = req && WB_WE_I;
  assign mode = cur.ctrl[`EDCCA_MODE_MSB:`EDCCA_MODE_LSB];
  assign ed_th = cur.ctrl[`EDCCA_EDTH_MSB:`EDCCA_EDTH_LSB];
  assign c_th = cur.ctrl[`EDCCA_CTH_MSB:`EDCCA_CTH_LSB];
  assign c_lim = cur.ctrl[`EDCCA_CNT_MSB:`EDCCA_CNT_LSB];
  assign over_ed = SAMPLE_VALID && (SAMPLE_ENERGY > ed_th);
  assign over_c = SAMPLE_VALID && (SAMPLE_CORR > c_th);
  // Zero limit disables carrier detect entirely
  assign carrier = (c_lim != 8'h00) && (cur.hits >= c_lim);
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
    end
  endgenerate
  always_comb begin
    case (mode)
      edcca_pkg::EDCCA_ENERGY_ONLY: busy_now = cur.energy_seen;
      edcca_pkg::EDCCA_CARRIER_ONLY: busy_now = carrier;
      edcca_pkg::EDCCA_CARRIER_AND_ENERGY: busy_now = carrier && cur.energy_seen;
      edcca_pkg::EDCCA_CARRIER_OR_ENERGY: busy_now = carrier || cur.energy_seen;
      edcca_pkg::EDCCA_ENERGY_FIRST_HIT_TEST: busy_now = cur.energy_seen;
      default: busy_now = cur.energy_seen;
    endcase
  end
  // ==========================================
  // Register bus and engine next state
  always_comb begin
    nxt = cur;
    nxt.ack = req;
    nxt.ed_end = 1'b0;
    nxt.cca_busy = 1'b0;
    nxt.cca_idle = 1'b0;
    if (wr) begin
      case (WB_ADR_I)
        `EDCCA_OFS_REPEAT: nxt.repeat_count = (cur.repeat_count & ~wmask) | (WB_DAT_I & wmask);
        `EDCCA_OFS_CTRL: nxt.ctrl = (cur.ctrl & ~wmask) | (WB_DAT_I & wmask);
        `EDCCA_OFS_CMD: begin
          // Commands ignored while an operation runs
          if (cur.fsm == edcca_pkg::EDCCA_IDLE && WB_SEL_I[0]) begin
            if (WB_DAT_I[`EDCCA_CMD_ED]) begin
              nxt.fsm = edcca_pkg::EDCCA_SCAN;
              nxt.left = cur.repeat_count;
              nxt.level = 8'h00;
            end else if (WB_DAT_I[`EDCCA_CMD_CCA]) begin
              nxt.fsm = edcca_pkg::EDCCA_ASSESS;
              nxt.hits = 8'h00;
              nxt.energy_seen = 1'b0;
            end
          end
        end
        default: nxt.ack = req;
      endcase
    end
    nxt.dat = 32'h00000000;
    if (req && !WB_WE_I) begin
      case (WB_ADR_I)
        `EDCCA_OFS_REPEAT: nxt.dat = cur.repeat_count;
        `EDCCA_OFS_LEVEL: nxt.dat = {24'h000000, cur.level};
        `EDCCA_OFS_CTRL: nxt.dat = cur.ctrl;
        `EDCCA_OFS_STATUS: begin
          nxt.dat[`EDCCA_ST_EDEND] = cur.ed_end;
          nxt.dat[`EDCCA_ST_BUSY] = cur.cca_busy;
          nxt.dat[`EDCCA_ST_IDLE] = cur.cca_idle;
          nxt.dat[`EDCCA_ST_RUN] = (cur.fsm != edcca_pkg::EDCCA_IDLE);
        end
        default: nxt.dat = 32'h00000000;
      endcase
    end
    // ==========================================
    // Scan and assessment sequencing
    case (cur.fsm)
      edcca_pkg::EDCCA_IDLE: begin
      end
      edcca_pkg::EDCCA_SCAN: begin
        if (SAMPLE_VALID) begin
          if (SAMPLE_ENERGY > cur.level) begin
            nxt.level = SAMPLE_ENERGY;
          end
          if (cur.left == 32'h00000000) begin
            nxt.fsm = edcca_pkg::EDCCA_IDLE;
            nxt.ed_end = 1'b1;
          end else begin
            nxt.left = cur.left - 32'h00000001;
          end
        end
      end
      edcca_pkg::EDCCA_ASSESS: begin
        if (over_ed) begin
          nxt.energy_seen = 1'b1;
        end
        if (over_c && cur.hits != 8'hff) begin
          nxt.hits = cur.hits + 8'h01;
        end
        // Test mode stops on the first raw sample over threshold
        if (mode == edcca_pkg::EDCCA_ENERGY_FIRST_HIT_TEST && over_ed) begin
          nxt.fsm = edcca_pkg::EDCCA_IDLE;
          nxt.cca_busy = 1'b1;
        end else if (ASSESS_WINDOW_END) begin
          // Decision uses flags from before this cycle's sample
          nxt.fsm = edcca_pkg::EDCCA_IDLE;
          nxt.cca_busy = busy_now;
          nxt.cca_idle = !busy_now;
        end
      end
      default: nxt.fsm = edcca_pkg::EDCCA_IDLE;
    endcase
  end
  // ==========================================
  // State register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cur <= '0;
      cur.ctrl <= `EDCCA_CTRL_RESET;
    end else if (CLK_EN) begin
      cur <= nxt;
    end
  end
  // ==========================================
  // Outputs
  assign WB_DAT_O = cur.dat;
  assign WB_ACK_O = cur.ack;
  assign ED_END = cur.ed_end;
  assign CCA_BUSY = cur.cca_busy;
  assign CCA_IDLE = cur.cca_idle;
  // ==========================================
  // Checks
  scan_single_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_SCAN && cur.left == 32'h0 && SAMPLE_VALID && CLK_EN) |=> ED_END)
    else $error("scan did not end on last sample");
  level_max_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_SCAN && SAMPLE_VALID && CLK_EN) |=> cur.level >= $past(SAMPLE_ENERGY))
    else $error("level below scanned sample");
  first_hit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_ASSESS && mode == 3'h4 && over_ed && CLK_EN) |=> CCA_BUSY && cur.fsm == 2'b00)
    else $error("test mode did not stop on first hit");
  carrier_only_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_ASSESS && mode == 3'h1 && c_lim == 8'h0 && ASSESS_WINDOW_END && CLK_EN) |=> CCA_IDLE)
    else $error("carrier mode busy with detection off");
  energy_busy_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_ASSESS && mode == 3'h0 && cur.energy_seen && ASSESS_WINDOW_END && CLK_EN) |=> CCA_BUSY)
    else $error("energy mode missed busy");
  outcome_excl_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !(CCA_BUSY && CCA_IDLE) && !(ED_END && (CCA_BUSY || CCA_IDLE)))
    else $error("events not distinct");
  ack_once_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    WB_ACK_O && CLK_EN |=> !WB_ACK_O)
    else $error("ack held two cycles");
  ctrl_write_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr && WB_ADR_I == `EDCCA_OFS_CTRL && WB_SEL_I == 4'hf && CLK_EN) |=> cur.ctrl == $past(WB_DAT_I))
    else $error("control write lost");
  ack_follows_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (req && CLK_EN) |=> WB_ACK_O)
    else $error("request not acknowledged");
  scan_start_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr && WB_ADR_I == `EDCCA_OFS_CMD && WB_DAT_I[0] && WB_SEL_I[0] && cur.fsm == edcca_pkg::EDCCA_IDLE && CLK_EN)
    |=> cur.level == 8'h00 && cur.left == $past(cur.repeat_count))
    else $error("scan start did not load count");
  carrier_busy_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_ASSESS && mode == 3'h1 && carrier && ASSESS_WINDOW_END && CLK_EN) |=> CCA_BUSY)
    else $error("carrier detect missed busy");
  energy_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cur.fsm == edcca_pkg::EDCCA_ASSESS && mode == 3'h0 && !cur.energy_seen && ASSESS_WINDOW_END && CLK_EN) |=> CCA_IDLE)
    else $error("energy mode missed idle");
  status_run_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (req && !WB_WE_I && WB_ADR_I == `EDCCA_OFS_STATUS && cur.fsm != edcca_pkg::EDCCA_IDLE && CLK_EN)
    |=> WB_DAT_O[`EDCCA_ST_RUN])
    else $error("status lost running bit");
  // Enable low must hold every bit, bus and engine alike
  freeze_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !CLK_EN |=> cur == $past(cur))
    else $error("state moved while frozen");
  scan_cov_c: cover property (@(posedge SYS_CLK) disable iff (RST) ED_END);
  first_hit_cov_c: cover property (@(posedge SYS_CLK) disable iff (RST) CCA_BUSY && mode == 3'h4);
  freeze_cov_c: cover property (@(posedge SYS_CLK) disable iff (RST) !CLK_EN && cur.fsm == edcca_pkg::EDCCA_SCAN);
  busy_cov_c: cover property (@(posedge SYS_CLK) disable iff (RST) CCA_BUSY && mode == 3'h3);
  idle_cov_c: cover property (@(posedge SYS_CLK) disable iff (RST) CCA_IDLE);
endmodule

// ---- sim/edcca_radio_model.sv ----
// Receive-path stand-in that feeds energy and correlator samples
`timescale 1ns/1ps
module edcca_radio_model (
  input wire logic clk,
  output logic valid,
  output logic [7:0] energy,
  output logic [7:0] corr,
  output logic wend
);
  initial begin
    valid = 1'b0;
    energy = 8'h00;
    corr = 8'h00;
    wend = 1'b0;
  end
  // Idle cycles invert the buses so a stale sample never looks valid
  task automatic beat(input logic [7:0] e, input logic [7:0] c, input logic v, input logic w);
    @(posedge clk);
    valid <= v;
    energy <= v ? e : ~energy;
    corr <= v ? c : ~corr;
    wend <= w;
  endtask
endmodule

// ---- sim/edcca_core_tb_top.sv ----
// Self-checking bench for the energy-detect and channel-assessment engine
`timescale 1ns/1ps
`include "edcca_params.svh"
module edcca_core_tb_top;
  typedef struct packed {logic [31:0] ctrl; logic [7:0] e; logic [7:0] c; logic w; logic busy;} edcca_row_t;
  logic SYS_CLK = 1'b0, RST = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic clk_en = 1'b1;
  logic [3:0] sel = 4'hf;
  localparam int SCALE = 4;
  localparam int OFFS = -92;
  int lvl_x [3] = '{'h22, 'h20, 'h05};
  int dbm_x [3] = '{44, 36, -72};
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic ack, valid, wend, ed_end, busy, idle, ed_s, busy_s, idle_s;
  logic [7:0] energy, corr;
  int errors = 0, total_checks = 0, cycles = 0;
  int nlist [3] = '{3, 1, 0};
  // ======================================
  // Assessment cases: ctrl, energy, corr, window end, busy
  edcca_row_t rows [8] = '{
    '{32'h01204000, 8'h41, 8'h00, 1'b1, 1'b1}, '{32'h01204000, 8'h40, 8'h30, 1'b1, 1'b0},
    '{32'h02204001, 8'h00, 8'h30, 1'b1, 1'b1}, '{32'h00204001, 8'hff, 8'h30, 1'b1, 1'b0},
    '{32'h01204002, 8'hff, 8'h00, 1'b1, 1'b0}, '{32'h01204003, 8'hff, 8'h00, 1'b1, 1'b1},
    '{32'h03204001, 8'h00, 8'h30, 1'b1, 1'b0}, '{32'h01204004, 8'h41, 8'h00, 1'b0, 1'b1}};
  always #20 SYS_CLK = ~SYS_CLK;
  edcca_radio_model u_radio (.clk(SYS_CLK), .valid(valid), .energy(energy), .corr(corr), .wend(wend));
  edcca_core u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(clk_en), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SAMPLE_VALID(valid),
    .SAMPLE_ENERGY(energy), .SAMPLE_CORR(corr), .ASSESS_WINDOW_END(wend), .ED_END(ed_end), .CCA_BUSY(busy),
    .CCA_IDLE(idle));
  // ======================================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge SYS_CLK);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge SYS_CLK); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  // Event pulses last one cycle, so every edge is sampled
  task automatic step(input logic [7:0] e, input logic [7:0] c, input logic v, input logic w);
    u_radio.beat(e, c, v, w);
    ed_s |= ed_end;
    busy_s |= busy;
    idle_s |= idle;
  endtask
  task automatic watch(input int n);
    repeat (n) step(8'h00, 8'h00, 1'b0, 1'b0);
  endtask
  // Software side conversion, saturating at eight bits
  function automatic logic [7:0] sw_scale(input logic [7:0] l);
    int p;
    p = l * SCALE;
    return (p > 255) ? 8'hff : 8'(p);
  endfunction
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  // ======================================
  // Main sequence
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    wb(1'b0, `EDCCA_OFS_CTRL, 32'h0, rd);
    chk("ctrl reset", rd, `EDCCA_CTRL_RESET);
    wb(1'b0, 12'h000, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    foreach (rows[i]) begin
      wb(1'b1, `EDCCA_OFS_CTRL, rows[i].ctrl, rd);
      wb(1'b0, `EDCCA_OFS_CTRL, 32'h0, rd);
      chk("ctrl", rd, rows[i].ctrl);
      wb(1'b1, `EDCCA_OFS_CMD, 32'h2, rd);
      {ed_s, busy_s, idle_s} = 3'b000;
      repeat (2) step(rows[i].e, rows[i].c, 1'b1, 1'b0);
      step(8'h00, 8'h00, 1'b0, rows[i].w);
      watch(4);
      chk("busy", busy_s, rows[i].busy);
      chk("idle", idle_s, !rows[i].busy);
    end
    // Largest count first, so a level left from an earlier scan shows up
    foreach (nlist[j]) begin
      wb(1'b1, `EDCCA_OFS_REPEAT, nlist[j], rd);
      wb(1'b1, `EDCCA_OFS_CMD, 32'h1, rd);
      {ed_s, busy_s, idle_s} = 3'b000;
      for (int k = 0; k < nlist[j]; k++) step(8'h20 + 8'(k), 8'h00, 1'b1, 1'b0);
      watch(2);
      chk("early end", ed_s, 1'b0);
      step(8'h05, 8'h00, 1'b1, 1'b0);
      watch(4);
      chk("scan end", {ed_s, busy_s, idle_s}, 3'b100);
      wb(1'b1, `EDCCA_OFS_LEVEL, 32'hff, rd);
      wb(1'b0, `EDCCA_OFS_LEVEL, 32'h0, rd);
      chk("level", rd, lvl_x[j]);
      chk("scaled dbm", int'(sw_scale(rd[7:0])) + OFFS, dbm_x[j]);
    end
    chk("saturate", sw_scale(8'h50), 8'hff);
    // Clock enable low must swallow a valid sample
    wb(1'b1, `EDCCA_OFS_CMD, 32'h1, rd);
    {ed_s, busy_s, idle_s} = 3'b000;
    clk_en <= 1'b0;
    step(8'h30, 8'h00, 1'b1, 1'b0);
    step(8'h00, 8'h00, 1'b0, 1'b0);
    clk_en <= 1'b1;
    watch(2);
    chk("frozen", ed_s, 1'b0);
    step(8'h07, 8'h00, 1'b1, 1'b0);
    watch(3);
    chk("thawed", ed_s, 1'b1);
    wb(1'b0, `EDCCA_OFS_LEVEL, 32'h0, rd);
    chk("frozen level", rd, 32'h07);
    // Reset in mid-scan must drop the run and restore control
    wb(1'b1, `EDCCA_OFS_CTRL, 32'h01204003, rd);
    wb(1'b1, `EDCCA_OFS_CMD, 32'h1, rd);
    wb(1'b0, `EDCCA_OFS_STATUS, 32'h0, rd);
    chk("running", rd, 32'h8);
    @(posedge SYS_CLK);
    RST <= 1'b1;
    @(posedge SYS_CLK);
    RST <= 1'b0;
    chk("outputs in reset", {ed_end, busy, idle, ack}, 4'h0);
    wb(1'b0, `EDCCA_OFS_STATUS, 32'h0, rd);
    chk("reset status", rd, 32'h0);
    wb(1'b0, `EDCCA_OFS_CTRL, 32'h0, rd);
    chk("reset ctrl", rd, `EDCCA_CTRL_RESET);
    sel <= 4'h2;
    wb(1'b1, `EDCCA_OFS_CTRL, 32'hffffffff, rd);
    sel <= 4'hf;
    wb(1'b0, `EDCCA_OFS_CTRL, 32'h0, rd);
    chk("lane write", rd, 32'h052dff00);
    stop_test();
  end
endmodule
